// file: wdsc_defines.vh
`ifndef WDSC_DEFINES_VH
`define WDSC_DEFINES_VH
// Byte addresses are four times the printed register index.
`define WDSC_IDX_INTCTL 8'h0B
`define WDSC_IDX_PFLAGS 8'h0C
`define WDSC_IDX_OPTION 8'h81
`define WDSC_IDX_PEN 8'h8C
`define WDSC_IDX_CFG 16'h2007
`define WDSC_IDX_CTRL 8'hF0
`define WDSC_IDX_STAT 8'hF1
`define WDSC_RST_INTCTL 8'h00
`define WDSC_RST_PFLAGS 8'h00
`define WDSC_RST_OPTION 8'hFF
`define WDSC_RST_PEN 8'h00
`define WDSC_PFLAGS_MASK 8'hC9
`define WDSC_OPT_ASSIGN 3
`define WDSC_CFG_FUSE 3
`define WDSC_CFG_PROTECT 7
`define WDSC_VECTOR 13'h0004
`define WDSC_WD_PERIOD_US 18000
`define WDSC_RC_KHZ 1
`define WDSC_WD_TICKS 18
`define WDSC_OST_TOSC 1024
`define WDSC_WD_CNT_W 16
`endif

// file: wdsc_top.v
// Functional notes
// R01 - Watchdog counts on its own RC tick
// R02 - Expiry while running gives device reset
// R03 - Expiry while sleeping wakes, continues execution
// R04 - Fuse zero keeps watchdog always off
// R05 - Unscaled expiry period is 18 ms
// R06 - Software assigns prescaler, up to 1:128
// R07 - Three-bit select picks power-of-two ratio
// R08 - Kick or sleep clears counter, prescaler
// R09 - Expiry clears active-low expiry flag
// R10 - Sleep entry updates flags, stops oscillator
// R11 - Watchdog reset never drives reset pin
// R12 - Wake on reset pin, watchdog, interrupt
// R13 - Sleep flag set at power-up, cleared sleeping
// R14 - Sleep prefetches next program address
// R15 - Enabled source wakes regardless of global
// R16 - After wake, vector only if global allowed
// R17 - Pending enabled flag makes immediate wake
// R18 - Watchdog wake or crystal-mode start-up clears watchdog counter; an interrupt wake without crystal mode leaves it uncleared
// R19 - Crystal modes wait 1024 periods before resume
// R20 - Interrupt entry saves only return address
// R21 - Readout only unprotected; unprotect erases all
// R22 - Flags set regardless of enables
//
// Added by the designer: register access over APB.
`include "wdsc_defines.vh"
module wdsc_top (
   input wire mclk_i,
   input wire rst_i,
   input wire rc_tick_i,
   input wire osc_tick_i,
   input wire crystal_mode_i,
   input wire [7:0] config_word_i,
   input wire external_reset_pin_i,
   input wire watchdog_kick_instr_i,
   input wire sleep_instr_i,
   input wire [12:0] pc_i,
   input wire irq_taken_i,
   input wire [2:0] intctl_evt_i,
   input wire [7:0] pflags_evt_i,
   input wire protect_off_req_i,
   input wire verify_read_req_i,
   input wire [31:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg device_reset_o,
   output reg external_reset_pin_drive_o,
   output reg osc_driver_on_o,
   output reg io_hold_o,
   output reg sleeping_o,
   output reg run_o,
   output reg prefetch_o,
   output reg [12:0] prefetch_addr_o,
   output reg vector_o,
   output reg [12:0] vector_addr_o,
   output reg push_return_o,
   output reg [12:0] return_addr_o,
   output reg verify_allow_o,
   output reg erase_all_o,
   output reg expiry_flag_n_o,
   output reg sleep_entry_flag_n_o
);
   localparam ST_RUN = 2'd0;
   localparam ST_SLEEP = 2'd1;
   localparam ST_OST = 2'd2;
   localparam ST_FIN = 2'd3;
   reg [1:0] st_q;
   reg [7:0] intctl_q;
   reg [7:0] pflags_q;
   reg [7:0] option_q;
   reg [7:0] pen_q;
   reg [`WDSC_WD_CNT_W-1:0] wd_q;
   reg [6:0] pre_q;
   reg [10:0] ost_q;
   reg irq_wake_q;
   reg expiry_flag_n_q;
   reg sleep_entry_flag_n_q;
   wire watchdog_fuse = config_word_i[`WDSC_CFG_FUSE];
   wire prescaler_assign = option_q[`WDSC_OPT_ASSIGN];
   wire [2:0] prescaler_ratio_sel = option_q[2:0];
   wire wr = psel & penable & pwrite;
   wire [29:0] idx = paddr[31:2];
   wire clr_wd = watchdog_kick_instr_i | (sleep_instr_i & (st_q == ST_RUN));
   // A prescaler stage output toggles when all lower bits are set; ratio 1:1 passes tick.
   wire [7:0] pre_ext = {1'b0, pre_q};
   wire pre_hit = (prescaler_ratio_sel == 3'd0) ? 1'b1 :
      (pre_ext & ((8'h01 << prescaler_ratio_sel) - 8'h01)) ==
      ((8'h01 << prescaler_ratio_sel) - 8'h01);
   wire wd_step = watchdog_fuse & rc_tick_i & (~prescaler_assign | pre_hit); // [R01] [R04] [R07]
   wire expire = wd_step & (wd_q == `WDSC_WD_TICKS - 1); // [R05] [R06]
   wire [7:0] int_pend = {3'b000, intctl_q[5:3] & intctl_q[2:0]};
   wire [7:0] per_pend = pflags_q & pen_q & {8{intctl_q[6]}};
   wire irq_pend = (|int_pend) | (|per_pend); // [R15] [R17]
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= ST_RUN;
         intctl_q <= `WDSC_RST_INTCTL;
         pflags_q <= `WDSC_RST_PFLAGS;
         option_q <= `WDSC_RST_OPTION;
         pen_q <= `WDSC_RST_PEN;
         wd_q <= {`WDSC_WD_CNT_W{1'b0}};
         pre_q <= 7'h00;
         ost_q <= 11'h000;
         irq_wake_q <= 1'b0;
         expiry_flag_n_q <= 1'b1;
         sleep_entry_flag_n_q <= 1'b1; // [R13]
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         device_reset_o <= 1'b0;
         external_reset_pin_drive_o <= 1'b1;
         osc_driver_on_o <= 1'b1;
         io_hold_o <= 1'b0;
         sleeping_o <= 1'b0;
         run_o <= 1'b1;
         prefetch_o <= 1'b0;
         prefetch_addr_o <= 13'h0000;
         vector_o <= 1'b0;
         vector_addr_o <= 13'h0000;
         push_return_o <= 1'b0;
         return_addr_o <= 13'h0000;
         verify_allow_o <= 1'b0;
         erase_all_o <= 1'b0;
         expiry_flag_n_o <= 1'b1;
         sleep_entry_flag_n_o <= 1'b1;
      end else begin
         // One wait state: pready rises one cycle after penable, and writes land on the next edge, where pready is sampled high.
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (psel & ~penable & ~pwrite) begin
            case (idx)
               {22'd0, `WDSC_IDX_INTCTL}: prdata <= {24'h0, intctl_q};
               {22'd0, `WDSC_IDX_PFLAGS}: prdata <= {24'h0, pflags_q};
               {22'd0, `WDSC_IDX_OPTION}: prdata <= {24'h0, option_q};
               {22'd0, `WDSC_IDX_PEN}: prdata <= {24'h0, pen_q};
               {14'd0, `WDSC_IDX_CFG}: prdata <= {24'h0, config_word_i};
               {22'd0, `WDSC_IDX_STAT}:
                  prdata <= {29'h0, st_q == ST_SLEEP, sleep_entry_flag_n_q, expiry_flag_n_q};
               default: prdata <= 32'h00000000;
            endcase
         end
         // Flag-setting events win over a software write in the same cycle; the write wins over irq_taken_i.
         if (wr & pready & (idx == {22'd0, `WDSC_IDX_INTCTL}))
            intctl_q <= pwdata[7:0] | {5'b0, intctl_evt_i}; // [R22]
         else if (irq_taken_i)
            intctl_q <= {1'b0, intctl_q[6:3], intctl_q[2:0] | intctl_evt_i};
         else
            intctl_q <= {intctl_q[7:3], intctl_q[2:0] | intctl_evt_i}; // [R22]
         if (wr & pready & (idx == {22'd0, `WDSC_IDX_PFLAGS}))
            pflags_q <= (pwdata[7:0] | pflags_evt_i) & `WDSC_PFLAGS_MASK;
         else
            pflags_q <= (pflags_q | pflags_evt_i) & `WDSC_PFLAGS_MASK; // [R22]
         if (wr & pready & (idx == {22'd0, `WDSC_IDX_OPTION}))
            option_q <= pwdata[7:0]; // [R06]
         if (wr & pready & (idx == {22'd0, `WDSC_IDX_PEN}))
            pen_q <= pwdata[7:0] & `WDSC_PFLAGS_MASK;
         if (wr & pready & (idx == {22'd0, `WDSC_IDX_CTRL}) & pwdata[0] &
             ~config_word_i[`WDSC_CFG_PROTECT])
            erase_all_o <= 1'b1; // [R21]
         else
            erase_all_o <= protect_off_req_i & ~config_word_i[`WDSC_CFG_PROTECT]; // [R21]
         verify_allow_o <= verify_read_req_i & config_word_i[`WDSC_CFG_PROTECT]; // [R21]
         if (clr_wd | expire | (st_q == ST_OST) | ~watchdog_fuse) begin
            wd_q <= {`WDSC_WD_CNT_W{1'b0}}; // [R08] [R18]
         end else if (wd_step) begin
            wd_q <= wd_q + {{(`WDSC_WD_CNT_W-1){1'b0}}, 1'b1};
         end
         if (clr_wd | ~prescaler_assign | (st_q == ST_OST) | wd_step)
            pre_q <= 7'h00; // [R08]
         else if (rc_tick_i)
            pre_q <= pre_q + 7'h01;
         if (watchdog_kick_instr_i)
            expiry_flag_n_q <= 1'b1;
         if (expire)
            expiry_flag_n_q <= 1'b0; // [R09]
         device_reset_o <= expire & (st_q == ST_RUN); // [R02]
         external_reset_pin_drive_o <= 1'b1; // [R11]
         prefetch_o <= 1'b0;
         vector_o <= 1'b0;
         push_return_o <= 1'b0;
         case (st_q)
            ST_RUN: begin
               if (sleep_instr_i & ~expire) begin
                  sleep_entry_flag_n_q <= 1'b0; // [R10] [R13]
                  expiry_flag_n_q <= 1'b1; // [R10]
                  prefetch_o <= 1'b1; // [R14]
                  prefetch_addr_o <= pc_i + 13'h0001; // [R14]
                  return_addr_o <= pc_i + 13'h0001;
                  st_q <= ST_SLEEP;
                  osc_driver_on_o <= 1'b0; // [R10]
                  io_hold_o <= 1'b1; // [R10]
                  sleeping_o <= 1'b1;
                  run_o <= 1'b0;
               end
            end
            ST_SLEEP: begin
               if (irq_pend | expire) begin // [R03] [R12] [R17]
                  irq_wake_q <= irq_pend & ~expire;
                  osc_driver_on_o <= 1'b1;
                  sleeping_o <= 1'b0;
                  ost_q <= 11'h000;
                  st_q <= crystal_mode_i ? ST_OST : ST_FIN;
               end
            end
            ST_OST: begin
               if (osc_tick_i) begin
                  ost_q <= ost_q + 11'h001;
                  if (ost_q == `WDSC_OST_TOSC - 1)
                     st_q <= ST_FIN; // [R19]
               end
            end
            ST_FIN: begin
               run_o <= 1'b1;
               io_hold_o <= 1'b0;
               st_q <= ST_RUN;
               if (irq_wake_q & intctl_q[7]) begin // [R16]
                  vector_o <= 1'b1;
                  vector_addr_o <= `WDSC_VECTOR;
                  push_return_o <= 1'b1; // [R20]
               end
            end
            default: st_q <= ST_RUN;
         endcase
         expiry_flag_n_o <= expiry_flag_n_q;
         sleep_entry_flag_n_o <= sleep_entry_flag_n_q;
      end
   end
   // The reset pin is an external input; rst_i already carries its wake-by-reset effect.
   wire unused_pin = external_reset_pin_i; // [R12]
endmodule // wdsc_top

// file: wdsc_checker.sv
module wdsc_checker (
   input logic mclk_i,
   input logic rst_i,
   input logic [7:0] config_word_i,
   input logic sleep_instr_i,
   input logic [12:0] pc_i,
   input logic device_reset_o,
   input logic external_reset_pin_drive_o,
   input logic osc_driver_on_o,
   input logic io_hold_o,
   input logic sleeping_o,
   input logic run_o,
   input logic prefetch_o,
   input logic [12:0] prefetch_addr_o,
   input logic vector_o,
   input logic [12:0] vector_addr_o,
   input logic verify_allow_o,
   input logic expiry_flag_n_o,
   input logic sleep_entry_flag_n_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_sleep_cmd;
      sleep_instr_i && run_o;
   endsequence
   // The flag output lags its internal flag by one cycle, hence the two-cycle window.
   sequence s_flag_after_sleep;
      ##[1:2] !sleep_entry_flag_n_o;
   endsequence
   property p_pin_kept;
      external_reset_pin_drive_o;
   endproperty
   a_pin_kept: assert property (p_pin_kept) else $error("reset pin pulled low");
   property p_sleep_state;
      sleeping_o |-> !osc_driver_on_o && io_hold_o;
   endproperty
   a_sleep_state: assert property (p_sleep_state) else $error("sleep state wrong");
   property p_sleep_flag;
      s_sleep_cmd |-> s_flag_after_sleep;
   endproperty
   a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag not cleared");
   property p_prefetch;
      s_sleep_cmd |=> prefetch_o && prefetch_addr_o == $past(pc_i) + 13'h0001;
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("prefetch wrong");
   property p_reset_run;
      device_reset_o |-> !sleeping_o ##[0:2] !expiry_flag_n_o;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("expiry reset wrong");
   property p_fuse_off;
      !config_word_i[3] && !$past(config_word_i[3]) |-> !device_reset_o;
   endproperty
   a_fuse_off: assert property (p_fuse_off) else $error("reset with fuse off");
   property p_vector;
      vector_o |-> vector_addr_o == 13'h0004;
   endproperty
   a_vector: assert property (p_vector) else $error("vector address wrong");
   property p_verify;
      verify_allow_o |-> $past(config_word_i[7]);
   endproperty
   a_verify: assert property (p_verify) else $error("readout while protected");
endmodule // wdsc_checker
bind wdsc_top wdsc_checker u_chk (.*);

// file: tb_wdsc_top.sv
`include "wdsc_defines.vh"
module tb_wdsc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i, rst_i, rc_tick_i, osc_tick_i, crystal_mode_i, external_reset_pin_i;
   logic watchdog_kick_instr_i, sleep_instr_i, irq_taken_i, protect_off_req_i, verify_read_req_i;
   logic psel, penable, pwrite, pready, pslverr, device_reset_o, external_reset_pin_drive_o;
   logic osc_driver_on_o, io_hold_o, sleeping_o, run_o, prefetch_o, vector_o, push_return_o;
   logic verify_allow_o, erase_all_o, expiry_flag_n_o, sleep_entry_flag_n_o;
   logic [7:0] config_word_i, pflags_evt_i;
   logic [2:0] intctl_evt_i;
   logic [12:0] pc_i, prefetch_addr_o, vector_addr_o, return_addr_o;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [1:0] div;
   logic [31:0] addrs [6] = '{32'h2C, 32'h30, 32'h204, 32'h230, 32'h3C4, 32'h100};
   logic [31:0] rsts [6] = '{32'h00, 32'h00, 32'hFF, 32'h00, 32'h03, 32'h00};
   int num_errors, checks, ticks, resets, vectors, n, r, i;
   wdsc_top uut (.*);
   initial begin
      mclk_i = 0;
      forever #5 mclk_i = ~mclk_i;
   end
   // One watchdog tick every four system clocks keeps the long ratios affordable.
   always @(posedge mclk_i) begin
      div <= div + 2'h1;
      rc_tick_i <= (div == 2'h3);
      ticks <= watchdog_kick_instr_i ? 0 : ticks + rc_tick_i;
      resets <= resets + device_reset_o;
      vectors <= vectors + vector_o;
   end
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step;
      @(posedge mclk_i);
      n++;
      if (n > 40000) begin
         num_errors++;
         give_verdict;
      end
   endtask
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1;
      n = 0;
      do step; while (pready !== 1'b1);
      q = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge mclk_i);
   endtask
   task automatic pulse(input logic [3:0] m);
      {irq_taken_i, sleep_instr_i, watchdog_kick_instr_i, intctl_evt_i[0]} <= m;
      @(posedge mclk_i);
      {irq_taken_i, sleep_instr_i, watchdog_kick_instr_i, intctl_evt_i[0]} <= 4'h0;
   endtask
   task automatic sleep_wake(input logic [3:0] ev);
      pulse(4'h4);
      repeat (4) @(posedge mclk_i);
      chk("asleep", 1, sleeping_o);
      if (ev != 0) pulse(ev);
      n = 0;
      while (sleeping_o !== 1'b0) step;
   endtask
   initial begin
      {rc_tick_i, osc_tick_i, crystal_mode_i, external_reset_pin_i, psel, penable, pwrite} = '0;
      {watchdog_kick_instr_i, sleep_instr_i, irq_taken_i, protect_off_req_i, div} = '0;
      {pflags_evt_i, intctl_evt_i, paddr, pwdata, ticks, resets, vectors} = '0;
      {num_errors, checks} = '0;
      {rst_i, verify_read_req_i, config_word_i, pc_i} = {2'h3, 8'h88, 13'h0123};
      repeat (4) @(posedge mclk_i);
      rst_i <= 0;
      for (i = 0; i < 6; i++) begin
         apb(addrs[i], 0, 0);
         chk("reset value", rsts[i], q);
      end
      $display("reset values done");
      for (i = 0; i < 9; i++) begin
         apb(32'h204, 1, (i < 8) ? (32'h8 | i) : 32'h0);
         pulse(4'h2);
         n = 0;
         while (device_reset_o !== 1'b1) step;
         chk("expiry ticks", `WDSC_WD_TICKS << (i % 8), ticks);
         repeat (3) @(posedge mclk_i);
         chk("expiry flag", 0, expiry_flag_n_o);
      end
      $display("prescaler ratios done");
      chk("readout allowed", 1, verify_allow_o);
      config_word_i <= 8'h80;
      r = resets;
      pulse(4'h2);
      repeat (100) @(posedge mclk_i);
      chk("resets with fuse off", r, resets);
      config_word_i <= 8'h88;
      apb(32'h204, 1, 0);
      sleep_wake(4'h0);
      apb(32'h3C4, 0, 0);
      chk("status after watchdog wake", 0, q);
      chk("resets after wake", r, resets);
      $display("watchdog sleep done");
      config_word_i <= 8'h00;
      apb(32'h2C, 1, 0);
      pulse(4'h1);
      apb(32'h2C, 0, 0);
      chk("flag without enable", 32'h01, q);
      chk("readout protected", 0, verify_allow_o);
      apb(32'h2C, 1, 32'h08);
      r = vectors;
      sleep_wake(4'h1);
      chk("vectors with allow off", r, vectors);
      pulse(4'h4);
      repeat (4) @(posedge mclk_i);
      chk("pending wake", 0, sleeping_o);
      apb(32'h2C, 1, 32'h88);
      sleep_wake(4'h1);
      repeat (4) @(posedge mclk_i);
      chk("vectored", 1, vectors > r);
      chk("return address", 32'h0124, return_addr_o);
      pulse(4'h8);
      apb(32'h2C, 0, 0);
      chk("allow cleared", 0, q[7]);
      $display("interrupt wake done");
      apb(32'h2C, 1, 32'h08);
      crystal_mode_i <= 1;
      osc_tick_i <= 1;
      sleep_wake(4'h1);
      repeat (1000) @(posedge mclk_i);
      chk("start-up wait", 0, run_o);
      n = 0;
      while (run_o !== 1'b1) step;
      chk("resumed after start-up", 1, run_o);
      $display("start-up wait done");
      protect_off_req_i <= 1;
      repeat (3) @(posedge mclk_i);
      chk("erase on unprotect", 1, erase_all_o);
      protect_off_req_i <= 0;
      $display("erase done");
      give_verdict;
   end
endmodule // tb_wdsc_top
